// >>> logic/cici_pkg.sv
// shared constants of the compass command interpreter and its two-wire host.
// assumes a 100 MHz ref_clk on both ends of the link.
// Function
// R1 - every command holds the device busy for its delay
// R2 - bridge offset update takes 6 ms
// R3 - calibration entry within 10 us
// R4 - calibration exit takes 14 ms
// R5 - mode save copies ram mode into eeprom
// R6 - sleep and wake commands, wake needs 100 us
// R7 - ram read: command plus address byte
// R8 - ram write: command, address, data bytes
// R9 - read commands fill the reply buffer
// R10 - reply fetched by a separate read transaction
// R11 - standby mode executes every command
// R12 - query and continuous outcomes left unspecified
// R13 - query or continuous: plain read returns heading
// R14 - get data: 6 ms, high then low byte
// R15 - reply bits msb first after ack clock
// R16 - master releases lines for slave driving
// R17 - x and y offsets from location 01
// R18 - summed count accepts 1 to 16, default 4
// R19 - eeprom write and read command formats
// R20 - device answers on eeprom slave address
// R21 - operating mode in ram 74, shadow 08
// R22 - output mode in ram 4e, not shadowed
package cici_pkg;
	localparam int unsigned CLK_NS        = 10;
	// command bytes
	localparam logic [7:0]  CMD_EE_WRITE  = 8'h77;
	localparam logic [7:0]  CMD_EE_READ   = 8'h72;
	localparam logic [7:0]  CMD_RAM_WRITE = 8'h47;
	localparam logic [7:0]  CMD_RAM_READ  = 8'h67;
	localparam logic [7:0]  CMD_SLEEP     = 8'h53;
	localparam logic [7:0]  CMD_WAKE      = 8'h57;
	localparam logic [7:0]  CMD_OFFSET    = 8'h4f;
	localparam logic [7:0]  CMD_CAL_ENTER = 8'h43;
	localparam logic [7:0]  CMD_CAL_EXIT  = 8'h45;
	localparam logic [7:0]  CMD_MODE_SAVE = 8'h4c;
	localparam logic [7:0]  CMD_GET_DATA  = 8'h41;
	// command delays in ns and in cycles (least times, rounded up)
	localparam int unsigned T_MEM_NS      = 70000;
	localparam int unsigned T_SLEEP_NS    = 10000;
	localparam int unsigned T_WAKE_NS     = 100000;
	localparam int unsigned T_OFFSET_NS   = 6000000;
	localparam int unsigned T_CALIN_NS    = 10000;
	localparam int unsigned T_CALOUT_NS   = 14000000;
	localparam int unsigned T_SAVE_NS     = 125000;
	localparam int unsigned T_GET_NS      = 6000000;
	localparam int unsigned MEM_CYC       = (T_MEM_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned SLEEP_CYC     = (T_SLEEP_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned WAKE_CYC      = (T_WAKE_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned OFFSET_CYC    = (T_OFFSET_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned CALIN_CYC     = (T_CALIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned CALOUT_CYC    = (T_CALOUT_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned SAVE_CYC      = (T_SAVE_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned GET_CYC       = (T_GET_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned TMR_W         = 24;
	typedef logic [TMR_W-1:0] cici_tmr_t;
	// eeprom map
	localparam int unsigned EE_DEPTH      = 9;
	localparam logic [7:0]  EE_LAST       = 8'h08;
	localparam logic [3:0]  EE_SLAVE      = 4'h0;
	localparam logic [3:0]  EE_X_HIGH     = 4'h1;
	localparam logic [3:0]  EE_X_LOW      = 4'h2;
	localparam logic [3:0]  EE_Y_HIGH     = 4'h3;
	localparam logic [3:0]  EE_Y_LOW      = 4'h4;
	localparam logic [3:0]  EE_DELAY      = 4'h5;
	localparam logic [3:0]  EE_SUM        = 4'h6;
	localparam logic [3:0]  EE_VERSION    = 4'h7;
	localparam logic [3:0]  EE_OPMODE     = 4'h8;
	localparam logic [7:0]  SLAVE_RST     = 8'h42;
	localparam logic [7:0]  DELAY_RST     = 8'h01;
	localparam logic [7:0]  SUM_RST       = 8'h04;
	localparam logic [7:0]  SUM_MIN       = 8'h01;
	localparam logic [7:0]  SUM_MAX       = 8'h10;
	localparam logic [7:0]  OPMODE_RST    = 8'h50;
	localparam logic [7:0]  FW_VERSION    = 8'h02;
	// ram map and operating mode field
	localparam logic [7:0]  RAM_OPMODE    = 8'h74;
	localparam logic [7:0]  RAM_OUTMODE   = 8'h4e;
	localparam logic [1:0]  MODE_STANDBY  = 2'h0;
	// host register map (byte addresses) and fields
	localparam logic [4:0]  H_CTRL        = 5'h00;
	localparam logic [4:0]  H_TX          = 5'h04;
	localparam logic [4:0]  H_RX          = 5'h08;
	localparam logic [4:0]  H_STATUS      = 5'h0c;
	localparam logic [4:0]  H_SLAVE       = 5'h10;
	localparam int unsigned CTRL_GO       = 0;
	localparam int unsigned CTRL_DIR      = 1;
	localparam int unsigned CTRL_CNT_LSB  = 2;
	localparam logic [6:0]  H_SLAVE_RST   = 7'h21;
	// link bit timing: three phases per bit, 10 us bit period
	localparam int unsigned T_BIT_NS      = 10000;
	localparam int unsigned PHASE_CYC     = (T_BIT_NS / 3 + CLK_NS - 1) / CLK_NS;
	localparam int unsigned PH_W          = 16;
	typedef enum {S_IDLE, S_ADDR, S_ACK, S_RX, S_TX, S_RACK} cici_slave_t;
	typedef enum {M_IDLE, M_START, M_BITS, M_STOP} cici_master_t;
endpackage : cici_pkg

// >>> logic/cici_link_if.sv
// two-wire link between the command interpreter and its host.
// open-drain: a line is low while any end enables a low output.
`timescale 1ns/1ps
interface cici_link_if;
	logic hostSclOut;
	logic hostSclOeN;
	logic hostSdaOut;
	logic hostSdaOeN;
	logic devSclOut;
	logic devSclOeN;
	logic devSdaOut;
	logic devSdaOeN;
	logic sclLine;
	logic sdaLine;
	assign sclLine = ~((~hostSclOeN & ~hostSclOut) | (~devSclOeN & ~devSclOut));
	assign sdaLine = ~((~hostSdaOeN & ~hostSdaOut) | (~devSdaOeN & ~devSdaOut));
	modport hostEnd (output hostSclOut, hostSclOeN, hostSdaOut, hostSdaOeN,
		input sclLine, sdaLine);
	modport devEnd (output devSclOut, devSclOeN, devSdaOut, devSdaOeN,
		input sclLine, sdaLine);
endinterface : cici_link_if

// >>> logic/cici_device.sv
// compass command interpreter: two-wire slave, eeprom map, ram, command timing.
// assumes the link lines of cici_link_if and a heading value from the measuring side.
//
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/1ps
module cici_device #(
	parameter int unsigned MEM_CYC    = cici_pkg::MEM_CYC,
	parameter int unsigned SLEEP_CYC  = cici_pkg::SLEEP_CYC,
	parameter int unsigned WAKE_CYC   = cici_pkg::WAKE_CYC,
	parameter int unsigned OFFSET_CYC = cici_pkg::OFFSET_CYC,
	parameter int unsigned CALIN_CYC  = cici_pkg::CALIN_CYC,
	parameter int unsigned CALOUT_CYC = cici_pkg::CALOUT_CYC,
	parameter int unsigned SAVE_CYC   = cici_pkg::SAVE_CYC,
	parameter int unsigned GET_CYC    = cici_pkg::GET_CYC,
	parameter logic [7:0]  FW_VER     = cici_pkg::FW_VERSION
) (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	// two-wire link
	cici_link_if.devEnd      link,
	// measuring side
	input  wire logic [15:0] headingIn,
	// status
	output logic             busy,
	output logic             sleeping,
	output logic             calibrating,
	output logic [7:0]       opMode,
	output logic [7:0]       outputMode
);
	import cici_pkg::*;

	localparam longint unsigned TMR_LIM = 64'd1 << TMR_W;
	if (MEM_CYC < 1 || SLEEP_CYC < 1 || WAKE_CYC < 1 || OFFSET_CYC < 1 || CALIN_CYC < 1
		|| CALOUT_CYC < 1 || SAVE_CYC < 1 || GET_CYC < 1 || MEM_CYC >= TMR_LIM
		|| WAKE_CYC >= TMR_LIM || OFFSET_CYC >= TMR_LIM || CALOUT_CYC >= TMR_LIM
		|| SAVE_CYC >= TMR_LIM || GET_CYC >= TMR_LIM || SLEEP_CYC >= TMR_LIM
		|| CALIN_CYC >= TMR_LIM) begin : g_bad_timing
		$error("command delay count out of timer range");
	end

	logic        sclS1, sclS2, sclD, sdaS1, sdaS2, sdaD;
	logic        pinLowReg, sclRelReg;
	cici_slave_t stReg, stNext;
	logic [3:0]  bitReg, bitNext;
	logic [7:0]  shReg, shNext;
	logic        sdaLowReg, sdaLowNext, rwReg, rwNext, selReg, selNext;
	logic [1:0]  nbReg, nbNext;
	logic [7:0]  cmdReg [3];
	logic [7:0]  cmdNext [3];
	logic [7:0]  repHiReg, repHiNext, repLoReg, repLoNext;
	logic [7:0]  eeReg [EE_DEPTH];
	logic [7:0]  eeNext [EE_DEPTH];
	logic [7:0]  ramReg [256];
	logic        ramWe;
	cici_tmr_t   tmrReg, tmrNext;
	logic        headPendReg, headPendNext, sleepReg, sleepNext, calReg, calNext;
	logic        busyReg, busyNext;
	logic        startEv, stopEv, sclRise, sclFall;
	logic [7:0]  txByte;

	// line sampling: first stage feeds only the second
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			sclS1 <= 1'b1;
			sclS2 <= 1'b1;
			sclD  <= 1'b1;
			sdaS1 <= 1'b1;
			sdaS2 <= 1'b1;
			sdaD  <= 1'b1;
		end else begin
			sclS1 <= link.sclLine;
			sclS2 <= sclS1;
			sclD  <= sclS2;
			sdaS1 <= link.sdaLine;
			sdaS2 <= sdaS1;
			sdaD  <= sdaS2;
		end
	end

	assign startEv = sclS2 & sdaD & ~sdaS2;
	assign stopEv  = sclS2 & ~sdaD & sdaS2;
	assign sclRise = sclS2 & ~sclD;
	assign sclFall = ~sclS2 & sclD;
	assign txByte  = selReg ? repLoReg : repHiReg;

	always_comb begin
		stNext       = stReg;
		bitNext      = bitReg;
		shNext       = shReg;
		sdaLowNext   = sdaLowReg;
		rwNext       = rwReg;
		nbNext       = nbReg;
		cmdNext      = cmdReg;
		selNext      = selReg;
		repHiNext    = repHiReg;
		repLoNext    = repLoReg;
		eeNext       = eeReg;
		tmrNext      = tmrReg;
		headPendNext = headPendReg;
		sleepNext    = sleepReg;
		calNext      = calReg;
		ramWe        = 1'b0;
		if (tmrReg != '0) begin
			tmrNext = tmrReg - 1'b1;
			if (tmrReg == cici_tmr_t'(1) && headPendReg) begin
				repHiNext    = headingIn[15:8]; // [R14] [R9]
				repLoNext    = headingIn[7:0]; // [R14]
				selNext      = 1'b0;
				headPendNext = 1'b0;
			end
		end
		if (startEv) begin
			stNext     = S_ADDR;
			bitNext    = '0;
			nbNext     = '0;
			sdaLowNext = 1'b0;
		end else if (stopEv) begin
			stNext     = S_IDLE;
			sdaLowNext = 1'b0;
			nbNext     = '0;
			// commands run only at the stop that ends the write [R10] [R11] [R12]
			if (!rwReg && nbReg != '0 && (!sleepReg || cmdReg[0] == CMD_WAKE)) begin
				case (cmdReg[0])
					CMD_EE_WRITE: begin
						tmrNext = cici_tmr_t'(MEM_CYC); // [R1]
						if (nbReg == 2'd3 && cmdReg[1] <= EE_LAST
							&& cmdReg[1][3:0] != EE_VERSION
							&& !(cmdReg[1][3:0] == EE_SUM
							&& (cmdReg[2] < SUM_MIN || cmdReg[2] > SUM_MAX))) begin
							eeNext[cmdReg[1][3:0]] = cmdReg[2]; // [R19] [R17] [R18]
						end
					end
					CMD_EE_READ: begin
						tmrNext   = cici_tmr_t'(MEM_CYC); // [R1]
						selNext   = 1'b0;
						repHiNext = (cmdReg[1] <= EE_LAST) ? eeReg[cmdReg[1][3:0]] : 8'h00; // [R19] [R9]
					end
					CMD_RAM_WRITE: begin
						tmrNext = cici_tmr_t'(MEM_CYC); // [R1]
						ramWe   = (nbReg == 2'd3); // [R8]
					end
					CMD_RAM_READ: begin
						tmrNext   = cici_tmr_t'(MEM_CYC); // [R1]
						selNext   = 1'b0;
						repHiNext = ramReg[cmdReg[1]]; // [R7] [R9]
					end
					CMD_SLEEP: begin
						tmrNext   = cici_tmr_t'(SLEEP_CYC); // [R6]
						sleepNext = 1'b1; // [R6]
					end
					CMD_WAKE: begin
						tmrNext   = cici_tmr_t'(WAKE_CYC); // [R6]
						sleepNext = 1'b0; // [R6]
					end
					CMD_OFFSET: tmrNext = cici_tmr_t'(OFFSET_CYC); // [R2]
					CMD_CAL_ENTER: begin
						tmrNext = cici_tmr_t'(CALIN_CYC); // [R3]
						calNext = 1'b1; // [R3]
					end
					CMD_CAL_EXIT: begin
						tmrNext = cici_tmr_t'(CALOUT_CYC); // [R4]
						calNext = 1'b0; // [R4]
					end
					CMD_MODE_SAVE: begin
						tmrNext           = cici_tmr_t'(SAVE_CYC); // [R5]
						eeNext[EE_OPMODE] = ramReg[RAM_OPMODE]; // [R5] [R21]
					end
					CMD_GET_DATA: begin
						tmrNext      = cici_tmr_t'(GET_CYC); // [R14]
						headPendNext = (ramReg[RAM_OPMODE][1:0] == MODE_STANDBY); // [R14]
					end
					default: ;
				endcase
			end
		end else begin
			case (stReg)
				S_ADDR, S_RX: begin
					if (sclRise && bitReg < 4'd8) begin
						shNext  = {shReg[6:0], sdaS2};
						bitNext = bitReg + 4'd1;
					end else if (sclFall && bitReg == 4'd8) begin
						if (stReg == S_ADDR) begin
							// a busy device refuses its address [R1]
							if (shReg[7:1] == eeReg[EE_SLAVE][7:1] && !busyReg) begin // [R20]
								sdaLowNext = 1'b1;
								rwNext     = shReg[0];
								stNext     = S_ACK;
								if (shReg[0] && ramReg[RAM_OPMODE][1:0] != MODE_STANDBY) begin
									repHiNext = headingIn[15:8]; // [R13]
									repLoNext = headingIn[7:0]; // [R13]
									selNext   = 1'b0;
								end
							end else begin
								stNext = S_IDLE;
							end
						end else if (nbReg != 2'd3) begin
							cmdNext[nbReg] = shReg;
							nbNext         = nbReg + 2'd1;
							sdaLowNext     = 1'b1;
							stNext         = S_ACK;
						end else begin
							stNext = S_IDLE;
						end
					end
				end
				S_ACK: begin
					if (sclFall) begin
						bitNext = 4'd0;
						stNext  = S_RX;
						sdaLowNext = 1'b0;
						if (rwReg) begin
							sdaLowNext = ~txByte[7]; // [R15]
							shNext     = {txByte[6:0], 1'b0};
							bitNext    = 4'd1;
							selNext    = 1'b1;
							stNext     = S_TX;
						end
					end
				end
				S_TX: begin
					if (sclFall) begin
						if (bitReg != 4'd8) begin
							sdaLowNext = ~shReg[7]; // [R15]
							shNext     = {shReg[6:0], 1'b0};
							bitNext    = bitReg + 4'd1;
						end else begin
							sdaLowNext = 1'b0;
							stNext     = S_RACK;
						end
					end
				end
				S_RACK: begin
					if (sclRise) begin
						bitNext = 4'd9;
						if (sdaS2) begin
							stNext = S_IDLE;
						end
					end else if (sclFall && bitReg == 4'd9) begin
						sdaLowNext = ~txByte[7]; // [R15]
						shNext     = {txByte[6:0], 1'b0};
						bitNext    = 4'd1;
						selNext    = 1'b1;
						stNext     = S_TX;
					end
				end
				default: ;
			endcase
		end
		busyNext = (tmrNext != '0);
	end

	// memories take constants at reset; eeprom acts as factory-fresh after every reset
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			stReg       <= S_IDLE;
			bitReg      <= '0;
			shReg       <= '0;
			sdaLowReg   <= 1'b0;
			rwReg       <= 1'b0;
			nbReg       <= '0;
			cmdReg      <= '{default: 8'h00};
			selReg      <= 1'b0;
			repHiReg    <= '0;
			repLoReg    <= '0;
			eeReg       <= '{SLAVE_RST, 8'h00, 8'h00, 8'h00, 8'h00, DELAY_RST, SUM_RST,
				FW_VER, OPMODE_RST};
			ramReg      <= '{default: 8'h00};
			ramReg[RAM_OPMODE] <= OPMODE_RST; // [R21]
			tmrReg      <= '0;
			headPendReg <= 1'b0;
			sleepReg    <= 1'b0;
			calReg      <= 1'b0;
			busyReg     <= 1'b0;
			pinLowReg   <= 1'b0;
			sclRelReg   <= 1'b1;
		end else begin
			stReg       <= stNext;
			bitReg      <= bitNext;
			shReg       <= shNext;
			sdaLowReg   <= sdaLowNext;
			rwReg       <= rwNext;
			nbReg       <= nbNext;
			cmdReg      <= cmdNext;
			selReg      <= selNext;
			repHiReg    <= repHiNext;
			repLoReg    <= repLoNext;
			eeReg       <= eeNext;
			if (ramWe) begin
				ramReg[cmdReg[1]] <= cmdReg[2]; // [R8] [R22]
			end
			tmrReg      <= tmrNext;
			headPendReg <= headPendNext;
			sleepReg    <= sleepNext;
			calReg      <= calNext;
			busyReg     <= busyNext;
			pinLowReg   <= 1'b0;
			sclRelReg   <= 1'b1;
		end
	end

	// no clock stretching: replies are buffered by the end of the read address byte
	assign link.devSclOut = pinLowReg;
	assign link.devSclOeN = sclRelReg;
	assign link.devSdaOut = pinLowReg;
	assign link.devSdaOeN = ~sdaLowReg;
	assign busy        = busyReg;
	assign sleeping    = sleepReg;
	assign calibrating = calReg;
	assign opMode      = ramReg[RAM_OPMODE];
	assign outputMode  = ramReg[RAM_OUTMODE];
endmodule : cici_device

// >>> logic/cici_host.sv
// host end: avalon-mm slave registers driving a two-wire bus master.
// assumes one bus master on the link; the device may stretch the clock.
`timescale 1ns/1ps
module cici_host #(
	parameter int unsigned PHASE_CYC = cici_pkg::PHASE_CYC
) (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	// avalon-mm slave
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	// two-wire link
	cici_link_if.hostEnd     link
);
	import cici_pkg::*;

	if (PHASE_CYC < 2 || PHASE_CYC >= (1 << PH_W)) begin : g_bad_phase
		$error("phase length out of range");
	end

	logic         sclS1, sclS2, sdaS1, sdaS2, pinLowReg;
	cici_master_t stReg, stNext;
	logic [1:0]   phReg, phNext, byteReg, byteNext, cntReg, cntNext;
	logic [PH_W-1:0] qReg, qNext;
	logic [3:0]   bitReg, bitNext;
	logic [7:0]   shReg, shNext;
	logic         dirReg, dirNext, nackReg, nackNext;
	logic         sclOeNReg, sclOeNNext, sdaOeNReg, sdaOeNNext;
	logic [23:0]  txReg, txNext;
	logic [15:0]  rxReg, rxNext;
	logic [6:0]   slaveReg, slaveNext;
	logic         waitReg, waitNext;
	logic [31:0]  rdReg, rdNext;
	logic         qDone, txing, drive;

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			sclS1 <= 1'b1;
			sclS2 <= 1'b1;
			sdaS1 <= 1'b1;
			sdaS2 <= 1'b1;
		end else begin
			sclS1 <= link.sclLine;
			sclS2 <= sclS1;
			sdaS1 <= link.sdaLine;
			sdaS2 <= sdaS1;
		end
	end

	assign qDone = (qReg == PH_W'(PHASE_CYC - 1));
	assign txing = (byteReg == 2'd0) || !dirReg;
	assign drive = (bitReg < 4'd8) ? (txing & ~shReg[7]) : (!txing && byteReg != cntReg);

	always_comb begin
		stNext     = stReg;
		phNext     = phReg;
		byteNext   = byteReg;
		cntNext    = cntReg;
		qNext      = (stReg == M_IDLE) ? '0 : qReg + 1'b1;
		bitNext    = bitReg;
		shNext     = shReg;
		dirNext    = dirReg;
		nackNext   = nackReg;
		sclOeNNext = sclOeNReg;
		sdaOeNNext = sdaOeNReg;
		txNext     = txReg;
		rxNext     = rxReg;
		slaveNext  = slaveReg;
		waitNext   = 1'b1;
		rdNext     = rdReg;
		// one wait cycle per access; the answer comes with waitrequest low
		if ((avs_read || avs_write) && waitReg) begin
			waitNext = 1'b0;
			if (avs_address == H_CTRL) begin
				rdNext = {28'h0, cntReg, dirReg, 1'b0};
			end else if (avs_address == H_TX) begin
				rdNext = {8'h00, txReg};
			end else if (avs_address == H_RX) begin
				rdNext = {16'h0000, rxReg};
			end else if (avs_address == H_STATUS) begin
				rdNext = {30'h0, nackReg, stReg != M_IDLE};
			end else if (avs_address == H_SLAVE) begin
				rdNext = {25'h0, slaveReg};
			end else begin
				rdNext = 32'h0;
			end
		end
		if (avs_write && !waitReg) begin
			if (avs_address == H_CTRL) begin
				// a start while busy or with no bytes is dropped
				if (stReg == M_IDLE && avs_writedata[CTRL_GO]
					&& avs_writedata[CTRL_CNT_LSB+:2] != 2'd0) begin
					dirNext  = avs_writedata[CTRL_DIR];
					cntNext  = avs_writedata[CTRL_CNT_LSB+:2];
					nackNext = 1'b0;
					rxNext   = '0;
					stNext   = M_START;
					qNext    = '0;
				end
			end else if (avs_address == H_TX) begin
				txNext = avs_writedata[23:0];
			end else if (avs_address == H_SLAVE) begin
				slaveNext = avs_writedata[6:0];
			end
		end
		case (stReg)
			M_START: begin
				sdaOeNNext = 1'b0;
				if (qDone) begin
					sclOeNNext = 1'b0;
					stNext     = M_BITS;
					phNext     = 2'd0;
					bitNext    = 4'd0;
					byteNext   = 2'd0;
					shNext     = {slaveReg, dirReg};
					qNext      = '0;
				end
			end
			M_BITS: begin
				case (phReg)
					2'd0: begin
						sdaOeNNext = ~drive; // [R16]
						if (qDone) begin
							phNext = 2'd1;
							qNext  = '0;
						end
					end
					2'd1: begin
						if (qDone) begin
							sclOeNNext = 1'b1; // [R16]
							phNext     = 2'd2;
							qNext      = '0;
						end
					end
					default: begin
						if (!sclS2) begin
							qNext = '0;
						end else if (qDone) begin
							sclOeNNext = 1'b0;
							phNext     = 2'd0;
							qNext      = '0;
							if (bitReg < 4'd8) begin
								shNext  = {shReg[6:0], sdaS2};
								bitNext = bitReg + 4'd1;
							end else begin
								bitNext = 4'd0;
								if (!txing) begin
									rxNext = {rxReg[7:0], shReg}; // [R14]
								end
								if (txing && sdaS2) begin
									nackNext = 1'b1;
									stNext   = M_STOP;
								end else if (byteReg == cntReg) begin
									stNext = M_STOP; // [R10]
								end else begin
									byteNext = byteReg + 2'd1;
									case (byteReg)
										2'd0: shNext = txReg[7:0]; // [R7] [R8] [R19]
										2'd1: shNext = txReg[15:8];
										default: shNext = txReg[23:16];
									endcase
								end
							end
						end
					end
				endcase
			end
			M_STOP: begin
				case (phReg)
					2'd0: begin
						sdaOeNNext = 1'b0;
						if (qDone) begin
							sclOeNNext = 1'b1;
							phNext     = 2'd1;
							qNext      = '0;
						end
					end
					2'd1: begin
						if (!sclS2) begin
							qNext = '0;
						end else if (qDone) begin
							sdaOeNNext = 1'b1; // [R16]
							phNext     = 2'd2;
							qNext      = '0;
						end
					end
					default: begin
						if (qDone) begin
							stNext = M_IDLE;
							phNext = 2'd0;
						end
					end
				endcase
			end
			default: ;
		endcase
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			stReg     <= M_IDLE;
			phReg     <= '0;
			byteReg   <= '0;
			cntReg    <= '0;
			qReg      <= '0;
			bitReg    <= '0;
			shReg     <= '0;
			dirReg    <= 1'b0;
			nackReg   <= 1'b0;
			sclOeNReg <= 1'b1;
			sdaOeNReg <= 1'b1;
			txReg     <= '0;
			rxReg     <= '0;
			slaveReg  <= H_SLAVE_RST;
			waitReg   <= 1'b1;
			rdReg     <= '0;
			pinLowReg <= 1'b0;
		end else begin
			stReg     <= stNext;
			phReg     <= phNext;
			byteReg   <= byteNext;
			cntReg    <= cntNext;
			qReg      <= qNext;
			bitReg    <= bitNext;
			shReg     <= shNext;
			dirReg    <= dirNext;
			nackReg   <= nackNext;
			sclOeNReg <= sclOeNNext;
			sdaOeNReg <= sdaOeNNext;
			txReg     <= txNext;
			rxReg     <= rxNext;
			slaveReg  <= slaveNext;
			waitReg   <= waitNext;
			rdReg     <= rdNext;
			pinLowReg <= 1'b0;
		end
	end

	assign link.hostSclOut = pinLowReg;
	assign link.hostSdaOut = pinLowReg;
	assign link.hostSclOeN = sclOeNReg;
	assign link.hostSdaOeN = sdaOeNReg;
	assign avs_readdata    = rdReg;
	assign avs_waitrequest = waitReg;
endmodule : cici_host

// >>> test/cici_link_chk.sv
// checker of the two-wire lines between host and device.
// assumes host PHASE_CYC of 8 and the resolved lines of cici_link_if.
`timescale 1ns/1ps
module cici_link_chk (
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// link lines
	input wire logic hostSdaOeN,
	input wire logic devSclOeN,
	input wire logic devSdaOeN,
	input wire logic sclLine,
	input wire logic sdaLine
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	sequence startCond;
		$fell(sdaLine) && sclLine;
	endsequence
	sequence stopCond;
		$rose(sdaLine) && sclLine;
	endsequence
	// high phase is counted once scl is seen high, so 8 is a floor
	a_no_stretch: assert property (devSclOeN) else $error("scl pulled");
	a_dev_sda_edge: assert property ($changed(devSdaOeN) |-> !sclLine) else $error("sda moved");
	a_addr_quiet: assert property (startCond |=> devSdaOeN [*8]) else $error("early drive");
	a_sda_level: assert property (sclLine |-> (hostSdaOeN || devSdaOeN)) else $error("level");
	a_scl_high: assert property ($rose(sclLine) |-> sclLine [*8]) else $error("short high");
	a_scl_low: assert property ($fell(sclLine) |-> !sclLine [*8]) else $error("short low");
	a_start_clock: assert property (startCond |-> ##[1:40] $fell(sclLine)) else $error("no clk");
	a_stop_idle: assert property (stopCond |=> (sdaLine && sclLine) [*3]) else $error("held");
endmodule : cici_link_chk

// >>> test/cici_tb_top.sv
// bench: host and device joined by the link, driven over avalon-mm.
// assumes shortened device delays; the two ends are each other's partner.
`timescale 1ns/1ps
module compass_i2c_command_interpreter_tb_top;
	import cici_pkg::*;
	localparam int MC = 20;
	localparam int LC = 30;
	localparam int SC = 10;
	localparam int OC = 600;
	logic        ref_clk, sys_rst, avs_read, avs_write, avs_waitrequest;
	logic        busy, sleeping, calibrating;
	logic [4:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata, q, st;
	logic [15:0] headingIn;
	logic [7:0]  opMode, outputMode;
	int          fails, num_checks, busyCnt;
	cici_link_if lnk ();
	cici_device #(.MEM_CYC(MC), .SLEEP_CYC(SC), .WAKE_CYC(MC), .OFFSET_CYC(OC),
		.CALIN_CYC(SC), .CALOUT_CYC(LC), .SAVE_CYC(MC), .GET_CYC(LC)) cici_device_i (
		.ref_clk, .sys_rst, .link(lnk), .headingIn, .busy, .sleeping, .calibrating,
		.opMode, .outputMode);
	cici_host #(.PHASE_CYC(8)) cici_host_i (.ref_clk, .sys_rst, .avs_address, .avs_read,
		.avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .link(lnk));
	cici_link_chk cici_link_chk_i (.ref_clk, .sys_rst, .hostSdaOeN(lnk.hostSdaOeN),
		.devSclOeN(lnk.devSclOeN), .devSdaOeN(lnk.devSdaOeN), .sclLine(lnk.sclLine),
		.sdaLine(lnk.sdaLine));
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) if (busy === 1'b1) busyCnt <= busyCnt + 1;
	task automatic report_and_stop;
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : report_and_stop
	task automatic lim(input int n, input int m);
		if (n >= m) begin
			fails++;
			report_and_stop();
		end
	endtask : lim
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("unexpected at %0t: got %h exp %h", $time, g, e);
		end
	endtask : chk
	// a registered output read just after an edge still holds the value from the edge before
	task automatic bus(input logic [4:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= ~w;
		avs_writedata <= d;
		do begin
			@(posedge ref_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		lim(n, 50);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : bus
	task automatic wt(input logic v, input int m);
		int n;
		n = 0;
		while (busy !== v && n < m) begin
			@(negedge ref_clk);
			n++;
		end
		lim(n, m);
	endtask : wt
	task automatic hw;
		int n;
		n = 0;
		do begin
			bus(H_STATUS, 1'b0, 32'h0);
			n++;
		end while (q[0] !== 1'b0 && n < 3000);
		lim(n, 3000);
		st = q;
	endtask : hw
	task automatic cmd(input logic [23:0] t, input logic [1:0] c);
		busyCnt = 0;
		bus(H_TX, 1'b1, {8'h0, t});
		bus(H_CTRL, 1'b1, {28'h0, c, 2'b01});
		hw();
		wt(1'b1, 20);
		wt(1'b0, 1000);
	endtask : cmd
	task automatic rd(input logic [1:0] c);
		bus(H_CTRL, 1'b1, {28'h0, c, 2'b11});
		hw();
		bus(H_RX, 1'b0, 32'h0);
	endtask : rd
	task automatic ee_rd(input logic [3:0] a);
		cmd({12'h0, a, CMD_EE_READ}, 2'd2);
		rd(2'd1);
	endtask : ee_rd
	task automatic s_reset;
		chk(32'(opMode), 32'h50);
		chk(32'(outputMode), 32'h0);
		bus(H_SLAVE, 1'b0, 32'h0);
		chk(q, 32'(H_SLAVE_RST));
		bus(5'h14, 1'b1, 32'hff);
		bus(5'h14, 1'b0, 32'h0);
		chk(q, 32'h0);
	endtask : s_reset
	task automatic s_ram;
		cmd({8'h55, 8'h7f, CMD_RAM_WRITE}, 2'd3);
		chk(busyCnt, MC);
		cmd({8'h00, 8'h7f, CMD_RAM_READ}, 2'd2);
		rd(2'd1);
		chk(q, 32'h55);
	endtask : s_ram
	task automatic s_ee;
		cmd({8'h11, 8'h06, CMD_EE_WRITE}, 2'd3);
		cmd({8'ha5, 8'h01, CMD_EE_WRITE}, 2'd3);
		cmd({8'hee, 8'h07, CMD_EE_WRITE}, 2'd3);
		ee_rd(EE_SUM);
		chk(q, 32'(SUM_RST));
		ee_rd(EE_X_HIGH);
		chk(q, 32'ha5);
		ee_rd(EE_SLAVE);
		chk(q, 32'(SLAVE_RST));
		ee_rd(EE_VERSION);
		chk(q, 32'(FW_VERSION));
	endtask : s_ee
	task automatic s_modes;
		logic [7:0] cb [7];
		int         cy [7];
		logic [1:0] fl [7];
		cb = '{CMD_OFFSET, CMD_CAL_ENTER, CMD_CAL_EXIT, CMD_MODE_SAVE, CMD_SLEEP, CMD_WAKE,
			CMD_GET_DATA};
		cy = '{OC, SC, LC, MC, SC, MC, LC};
		fl = '{2'b00, 2'b10, 2'b00, 2'b00, 2'b01, 2'b00, 2'b00};
		cmd({8'h60, RAM_OPMODE, CMD_RAM_WRITE}, 2'd3);
		chk(32'(opMode), 32'h60);
		cmd({8'h01, RAM_OUTMODE, CMD_RAM_WRITE}, 2'd3);
		chk(32'(outputMode), 32'h01);
		for (int i = 0; i < 7; i++) begin
			cmd({16'h0, cb[i]}, 2'd1);
			chk(busyCnt, cy[i]);
			chk(32'({calibrating, sleeping}), 32'(fl[i]));
		end
		rd(2'd2);
		chk(q, 32'h1234);
		ee_rd(EE_OPMODE);
		chk(q, 32'h60);
	endtask : s_modes
	// a second address while the long timer runs must be refused
	task automatic s_refuse;
		bus(H_TX, 1'b1, 32'(CMD_OFFSET));
		bus(H_CTRL, 1'b1, 32'h5);
		hw();
		bus(H_CTRL, 1'b1, 32'h5);
		hw();
		chk(32'(st[1]), 32'h1);
		wt(1'b0, 1000);
	endtask : s_refuse
	task automatic s_query;
		cmd({8'h51, RAM_OPMODE, CMD_RAM_WRITE}, 2'd3);
		@(posedge ref_clk);
		headingIn <= 16'hbeef;
		rd(2'd2);
		chk(q, 32'hbeef);
	endtask : s_query
	initial begin
		sys_rst = 1'b1;
		{avs_read, avs_write, avs_address, avs_writedata} = '0;
		headingIn = 16'h1234;
		{fails, num_checks, busyCnt} = '0;
		repeat (5) @(posedge ref_clk);
		sys_rst <= 1'b0;
		s_reset();
		s_ram();
		s_ee();
		s_modes();
		s_refuse();
		s_query();
		@(posedge ref_clk);
		sys_rst <= 1'b1;
		@(posedge ref_clk);
		sys_rst <= 1'b0;
		s_reset();
		report_and_stop();
	end
endmodule : compass_i2c_command_interpreter_tb_top
